// ---- logic/lpm_poll_config.v ----
`timescale 1ns/10ps
`include "lpm_poll_consts.vh"

module lpm_poll_config #(
  parameter POLL_WIN_CYC = `POLL_WIN_CYC_DEF,                // base polling window, cycles
  parameter DEB_EXT_CYC  = (`DEB_EXT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire                clk_i,            // 40 MHz clock
  input  wire                rst_n_i,          // async reset, active low
  input  wire                spi_sclk_i,       // serial clock from master
  input  wire                spi_cs_n_i,       // chip select, active low
  input  wire                spi_mosi_i,       // serial data in
  output reg                 spi_miso_o,       // serial data out
  output reg                 spi_miso_oe_o,    // miso drive enable
  input  wire                fault_i,          // fault status for reply
  input  wire                int_flag_i,       // interrupt flag for reply
  input  wire                low_power_i,      // low-power state active
  input  wire                poll_tick_i,      // normal-rate polling tick
  input  wire [`PRG_CH-1:0]  prg_to_batt_i,    // programmable channel wired to battery
  input  wire [`PRG_CH-1:0]  prg_wetting_current_sel_i,   // programmable channel wetting select
  output reg  [`GND_CH-1:0]  gnd_wetting_current_sel_o,   // 1 wetting current, 0 1.0 mA
  output reg  [`PRG_CH-1:0]  prg_hi_cur_o,     // 1 normal 2.2 mA, 0 1.0 mA or wetting
  output reg  [`GND_CH-1:0]  gnd_drive_o,      // ground channel polling current on
  output reg  [`PRG_CH-1:0]  prg_drive_o,      // programmable polling current on
  output reg  [`GND_CH-1:0]  gnd_sample_o,     // ground channel judge pulse
  output reg  [`PRG_CH-1:0]  prg_sample_o,     // programmable judge pulse
  output reg  [`PRG_CH-1:0]  prg_level_mode_o  // 1 judge final level, 0 delta
);

  // one-hot window states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BASE = 3'b010;
  localparam [2:0] ST_EXT  = 3'b100;
  // last count of each window, cut to the counter width on purpose
  localparam integer WIN_LAST_I = POLL_WIN_CYC - 1;
  localparam integer EXT_LAST_I = DEB_EXT_CYC - 1;
  localparam [16:0]  WIN_LAST   = WIN_LAST_I[16:0];
  localparam [16:0]  EXT_LAST   = EXT_LAST_I[16:0];

  // polling is due on every tick, or on one tick in four when slow
  function due;
    input                     slow;
    input [`SLOW_PHASE_W-1:0] phase;
    begin
      due = ~slow | (phase == `SLOW_PHASE_ZERO); // RQ3 RQ4
    end
  endfunction

  // synchronisers: stage 1 feeds only stage 2
  reg [2:0] sclk_s_q;
  reg [1:0] cs_s_q;
  reg [1:0] mosi_s_q;
  reg       cs_n_prev_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_s_q    <= 3'h0;
      // select resets high so no false select edge follows reset
      cs_s_q      <= 2'h3;
      mosi_s_q    <= 2'h0;
      cs_n_prev_q <= 1'b1;
    end else begin
      sclk_s_q    <= {sclk_s_q[1:0], spi_sclk_i};
      cs_s_q      <= {cs_s_q[0], spi_cs_n_i};
      mosi_s_q    <= {mosi_s_q[0], spi_mosi_i};
      cs_n_prev_q <= cs_s_q[1];
    end
  end

  // edges seen through the synchronisers, two clocks behind the pins
  wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  wire cs_n      = cs_s_q[1];
  wire cs_fall   = ~cs_n & cs_n_prev_q;
  wire cs_rise   = cs_n & ~cs_n_prev_q;

  // configuration registers
  reg [`GND_CH-1:0] gnd_cur_q;
  reg [`PRG_CH-1:0] prg_slow_q;
  reg [`GND_CH-1:0] gnd_slow_q;
  reg [`PRG_CH-1:0] prg_deb_q;

  // frame shifter and reply
  reg [31:0]           sin_q;
  reg [31:0]           sout_q;
  reg [5:0]            bits_q;
  reg [`REP_DAT_HI:0]  rdata_q;

  // read mux over the four registers, unmapped reads zero
  reg [`REP_DAT_HI:0] rd_val;
  always @* begin
    rd_val = {(`REP_DAT_HI+1){1'b0}};
    case (sin_q[`FRM_ADR_HI:`FRM_ADR_LO])
      `ADR_GND_CUR:  rd_val[`GND_CH-1:0] = gnd_cur_q;  // RQ7
      `ADR_PRG_SLOW: rd_val[`PRG_CH-1:0] = prg_slow_q; // RQ8
      `ADR_GND_SLOW: rd_val[`GND_CH-1:0] = gnd_slow_q; // RQ9
      `ADR_PRG_DEB:  rd_val[`PRG_CH-1:0] = prg_deb_q;  // RQ10
      default:       rd_val = {(`REP_DAT_HI+1){1'b0}};
    endcase
  end

  // a frame counts only when exactly one word of clock rises came between selects
  wire frame_ok = cs_rise & (bits_q == `FRAME_BITS);
  wire wr_en    = frame_ok & sin_q[`FRM_RW];                 // RQ11
  wire [6:0] adr = sin_q[`FRM_ADR_HI:`FRM_ADR_LO];           // RQ11

  // a write answers with what was stored, masked to the register width
  wire [`REP_DAT_HI:0] wr_echo = {{(`REP_DAT_HI+1-`GND_CH){1'b0}}, sin_q[`GND_CH-1:0]} &
                                 rd_mask(adr);

  // register writes; a short or long frame is dropped whole
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gnd_cur_q  <= `GND_RST; // RQ7
      prg_slow_q <= `PRG_RST; // RQ8
      gnd_slow_q <= `GND_RST; // RQ9
      prg_deb_q  <= `PRG_RST; // RQ10
    end else if (wr_en) begin
      if (adr == `ADR_GND_CUR)
        gnd_cur_q <= sin_q[`GND_CH-1:0];  // RQ7
      if (adr == `ADR_PRG_SLOW)
        prg_slow_q <= sin_q[`PRG_CH-1:0]; // RQ8
      if (adr == `ADR_GND_SLOW)
        gnd_slow_q <= sin_q[`GND_CH-1:0]; // RQ9
      if (adr == `ADR_PRG_DEB)
        prg_deb_q <= sin_q[`PRG_CH-1:0];  // RQ10
    end
  end

  // serial shifting, mode 0: sample on rise, shift out on fall
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sin_q         <= 32'h0000_0000;
      sout_q        <= 32'h0000_0000;
      bits_q        <= 6'h00;
      rdata_q       <= {(`REP_DAT_HI+1){1'b0}};
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
    end else begin
      // miso is driven from one clock after the synchronised select falls until one clock after it rises
      spi_miso_oe_o <= ~cs_n;
      if (cs_fall) begin
        // reply carries the answer to the previous good frame
        sout_q     <= {8'h00, fault_i, int_flag_i, rdata_q}; // RQ11
        spi_miso_o <= 1'b0;
        bits_q     <= 6'h00;
      end else if (!cs_n && sclk_rise) begin
        // mosi passes the same two stages as the clock, so the two stay aligned
        sin_q <= {sin_q[30:0], mosi_s_q[1]};
        // saturate so an overlong frame is seen as bad
        if (bits_q != `FRAME_BITS + 6'h01)
          bits_q <= bits_q + 6'h01;
        spi_miso_o <= sout_q[31];
        sout_q     <= {sout_q[30:0], 1'b0};
      end else if (!cs_n && sclk_fall) begin
        // the fall shows the next bit, which the master takes at its next fall
        spi_miso_o <= sout_q[31];
      end
      // a good frame sets the answer that the next frame carries
      if (frame_ok) begin
        if (sin_q[`FRM_RW])
          rdata_q <= wr_echo;
        else
          rdata_q <= rd_val;
      end
    end
  end

  // width of each register, so a write echo shows what was stored
  function [`REP_DAT_HI:0] rd_mask;
    input [6:0] a;
    begin
      case (a)
        `ADR_GND_CUR, `ADR_GND_SLOW:
          rd_mask = {{(`REP_DAT_HI+1-`GND_CH){1'b0}}, {`GND_CH{1'b1}}};
        `ADR_PRG_SLOW, `ADR_PRG_DEB:
          rd_mask = {{(`REP_DAT_HI+1-`PRG_CH){1'b0}}, {`PRG_CH{1'b1}}};
        default:
          rd_mask = {(`REP_DAT_HI+1){1'b0}};
      endcase
    end
  endfunction

  // current selection is static, so it follows the registers and the battery and wetting select inputs directly
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gnd_wetting_current_sel_o   <= `GND_RST;
      prg_hi_cur_o     <= `PRG_RST;
      prg_level_mode_o <= `PRG_RST;
    end else begin
      gnd_wetting_current_sel_o   <= gnd_cur_q;                        // RQ1 RQ2
      prg_hi_cur_o     <= prg_to_batt_i & ~prg_wetting_current_sel_i;  // RQ12
      prg_level_mode_o <= prg_deb_q;                        // RQ5 RQ6
    end
  end

  // per channel quarter-rate phase, restarted outside low power
  reg [`SLOW_PHASE_W-1:0] gph_q [0:`GND_CH-1];
  reg [`SLOW_PHASE_W-1:0] pph_q [0:`PRG_CH-1];
  reg [`GND_CH-1:0]       due_g;
  reg [`PRG_CH-1:0]       due_p;
  integer i; // loop index of the due decode
  integer j; // loop index of the phase counters

  // which channels take part in the window that the next tick opens
  always @* begin
    due_g = {`GND_CH{1'b0}};
    due_p = {`PRG_CH{1'b0}};
    for (i = 0; i < `GND_CH; i = i + 1)
      due_g[i] = due(gnd_slow_q[i], gph_q[i]); // RQ3 RQ4
    for (i = 0; i < `PRG_CH; i = i + 1)
      due_p[i] = due(prg_slow_q[i], pph_q[i]); // RQ3 RQ4
  end

  // phases advance on every tick in low power, so a tick lost to a busy window still counts
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (j = 0; j < `GND_CH; j = j + 1)
        gph_q[j] <= `SLOW_PHASE_ZERO;
      for (j = 0; j < `PRG_CH; j = j + 1)
        pph_q[j] <= `SLOW_PHASE_ZERO;
    end else if (!low_power_i) begin
      // outside low power every channel starts again at phase zero
      for (j = 0; j < `GND_CH; j = j + 1)
        gph_q[j] <= `SLOW_PHASE_ZERO;
      for (j = 0; j < `PRG_CH; j = j + 1)
        pph_q[j] <= `SLOW_PHASE_ZERO;
    end else if (poll_tick_i) begin
      for (j = 0; j < `GND_CH; j = j + 1)
        gph_q[j] <= gph_q[j] + 2'h1; // RQ4
      for (j = 0; j < `PRG_CH; j = j + 1)
        pph_q[j] <= pph_q[j] + 2'h1; // RQ4
    end
  end

  // polling window; ticks that land in a busy window are skipped
  reg [2:0]         st_q;
  reg [16:0]        cnt_q;
  reg [`PRG_CH-1:0] deb_q;
  reg [`PRG_CH-1:0] act_p_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q         <= ST_IDLE;
      cnt_q        <= 17'h0_0000;
      deb_q        <= `PRG_RST;
      act_p_q      <= `PRG_RST;
      gnd_drive_o  <= `GND_RST;
      prg_drive_o  <= `PRG_RST;
      gnd_sample_o <= `GND_RST;
      prg_sample_o <= `PRG_RST;
    end else begin
      gnd_sample_o <= `GND_RST;
      prg_sample_o <= `PRG_RST;
      // free-running count; every state that reads it restarts it on entry
      cnt_q        <= cnt_q + 17'h0_0001;
      case (st_q)
        ST_IDLE: begin
          if (low_power_i && poll_tick_i) begin
            st_q        <= ST_BASE;
            cnt_q       <= 17'h0_0000;
            deb_q       <= prg_deb_q;
            act_p_q     <= due_p;
            gnd_drive_o <= due_g; // RQ3 RQ4
            prg_drive_o <= due_p; // RQ3 RQ4
          end
        end
        // base window: delta channels are judged, debounce channels carry on
        ST_BASE: begin
          if (cnt_q == WIN_LAST) begin
            gnd_sample_o <= gnd_drive_o;              // RQ1 RQ2
            prg_sample_o <= act_p_q & ~deb_q;         // RQ5
            gnd_drive_o  <= `GND_RST;
            prg_drive_o  <= act_p_q & deb_q;          // RQ6
            cnt_q        <= 17'h0_0000;
            st_q         <= |(act_p_q & deb_q) ? ST_EXT : ST_IDLE;
          end
        end
        // extension for the debounce channels only
        ST_EXT: begin
          if (cnt_q == EXT_LAST) begin
            prg_sample_o <= act_p_q & deb_q; // RQ6
            prg_drive_o  <= `PRG_RST;
            st_q         <= ST_IDLE;
          end
        end
        // an illegal state drops every drive and idles
        default: begin
          st_q        <= ST_IDLE;
          gnd_drive_o <= `GND_RST;
          prg_drive_o <= `PRG_RST;
        end
      endcase
      // leaving low power ends any window without judging
      if (!low_power_i && st_q != ST_IDLE) begin
        st_q         <= ST_IDLE;
        gnd_sample_o <= `GND_RST;
        prg_sample_o <= `PRG_RST;
        gnd_drive_o <= `GND_RST;
        prg_drive_o <= `PRG_RST;
      end
    end
  end

endmodule // lpm_poll_config

// ---- logic/lpm_poll_consts.vh ----
// Operation
// RQ1: ground channel current bit 0 selects the normal 1.0 mA low-power polling current.
// RQ2: ground channel current bit 1 polls with the configured wetting current.
// RQ3: slow bit 0 polls the channel at the normal low-power rate.
// RQ4: slow bit 1 stretches the channel polling interval to four normal intervals.
// RQ5: debounce bit 0 judges a programmable channel by voltage difference in normal window.
// RQ6: debounce bit 1 keeps polling current 1.2 ms longer, then judges final level.
// RQ7: ground current select register at 0x17, bits 13..0, clear at power-on.
// RQ8: programmable slow register at 0x18, bits 7..0, clear at power-on.
// RQ9: ground slow register at 0x19, bits 13..0, clear at power-on.
// RQ10: programmable debounce register at 0x1a, bits 7..0, clear at power-on.
// RQ11: frame: address 31..25, rw 24, data 23..0; reply fault 23, flag 22, data 21..0.
// RQ12: programmable normal current is 2.2 mA to battery, 1.0 mA to ground.
`ifndef LPM_POLL_CONSTS_VH
`define LPM_POLL_CONSTS_VH

// register addresses, 7 bit
`define ADR_GND_CUR      7'h17
`define ADR_PRG_SLOW     7'h18
`define ADR_GND_SLOW     7'h19
`define ADR_PRG_DEB      7'h1a

// frame layout
`define FRAME_BITS       6'h20
`define FRM_ADR_HI       31
`define FRM_ADR_LO       25
`define FRM_RW           24
`define FRM_DAT_HI       23
`define REP_FAULT        23
`define REP_FLAG         22
`define REP_DAT_HI       21

// channel counts and reset values
`define GND_CH           14
`define PRG_CH           8
`define GND_RST          14'h0000
`define PRG_RST          8'h00

// slow polling divides the rate by four
`define SLOW_PHASE_W     2
`define SLOW_PHASE_ZERO  2'h0

// timing
`define CLK_PERIOD_NS    25
`define DEB_EXT_NS       1200000
`define POLL_WIN_CYC_DEF 16

`endif

// ---- sim/lpm_poll_config_assertions.sv ----
`timescale 1ns/10ps
`include "lpm_poll_consts.vh"
module lpm_poll_config_assertions #(
  parameter POLL_WIN_CYC = 16,
  parameter DEB_EXT_CYC  = 48000
) (
  input wire               clk_i,         // clock
  input wire               rst_n_i,       // reset, active low
  input wire               spi_cs_n_i,    // select
  input wire               spi_miso_oe_o, // miso enable
  input wire               low_power_i,   // low-power state
  input wire [`PRG_CH-1:0] prg_to_batt_i, // battery wiring
  input wire [`PRG_CH-1:0] prg_wetting_current_sel_i,// wetting select
  input wire [`PRG_CH-1:0] prg_hi_cur_o,  // 2.2 mA select
  input wire [`GND_CH-1:0] gnd_drive_o,   // ground drive
  input wire [`PRG_CH-1:0] prg_drive_o,   // prog drive
  input wire [`GND_CH-1:0] gnd_sample_o   // ground judge
);
  reg [15:0] gw_q; // cycles ground drive has been on
  reg [15:0] pw_q; // cycles prog drive has been on
  // run lengths, so window lengths can be checked past any repetition limit
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gw_q <= 16'h0000;
      pw_q <= 16'h0000;
    end else begin
      gw_q <= (|gnd_drive_o) ? gw_q + 16'h0001 : 16'h0000;
      pw_q <= (|prg_drive_o) ? pw_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_oe_on_select: assert property ($fell(spi_cs_n_i) |-> ##[2:6] spi_miso_oe_o)
    else $error("miso enable late");
  a_oe_off_idle: assert property (spi_cs_n_i [*6] |-> !spi_miso_oe_o)
    else $error("miso driven while idle");
  a_no_drive_awake: assert property (
    !low_power_i [*3] |-> gnd_drive_o == 0 && prg_drive_o == 0)
    else $error("drive outside low power");
  a_gnd_win_len: assert property (
    $fell(|gnd_drive_o) && low_power_i |-> gw_q == POLL_WIN_CYC)
    else $error("ground window length");
  a_prg_win_len: assert property ($fell(|prg_drive_o) && low_power_i |->
    pw_q == POLL_WIN_CYC || pw_q == POLL_WIN_CYC + DEB_EXT_CYC)
    else $error("prog window length");
  a_smp_pulse: assert property (gnd_sample_o != 0 |=> gnd_sample_o == 0)
    else $error("judge pulse too long");
  a_smp_driven: assert property (
    gnd_sample_o != 0 |-> (gnd_sample_o & ~$past(gnd_drive_o)) == 0 && gnd_drive_o == 0)
    else $error("judge without drive");
  a_prg_hi_cur: assert property (
    $stable(prg_to_batt_i) && $stable(prg_wetting_current_sel_i) && $past(rst_n_i)
    |=> prg_hi_cur_o == ($past(prg_to_batt_i) & ~$past(prg_wetting_current_sel_i)))
    else $error("prog current code");
endmodule // lpm_poll_config_assertions
bind lpm_poll_config lpm_poll_config_assertions #(
  .POLL_WIN_CYC(POLL_WIN_CYC), .DEB_EXT_CYC(DEB_EXT_CYC)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_miso_oe_o(spi_miso_oe_o), .low_power_i(low_power_i),
  .prg_to_batt_i(prg_to_batt_i), .prg_wetting_current_sel_i(prg_wetting_current_sel_i),
  .prg_hi_cur_o(prg_hi_cur_o), .gnd_drive_o(gnd_drive_o),
  .prg_drive_o(prg_drive_o), .gnd_sample_o(gnd_sample_o));

// ---- sim/spi_master_model.sv ----
`timescale 1ns/10ps
module spi_master_model (
  input  wire clk_i,  // system clock
  output reg  sclk_o, // serial clock, idle low
  output reg  cs_n_o, // select, active low
  output reg  mosi_o, // data to device
  input  wire miso_i  // data from device
);
  integer i;
  // idle bus at time zero
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // mode 0, msb first; half period of 6 clocks leaves room for the synchronisers
  task xfer(input integer n, input [31:0] w, output [31:0] r);
    begin
      r = 32'h0000_0000;
      cs_n_o <= 1'b0;
      mosi_o <= w[31];
      for (i = 0; i < n; i = i + 1) begin
        repeat (6) @(posedge clk_i);
        sclk_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        sclk_o <= 1'b0;
        r = {r[30:0], miso_i}; // reply taken as the clock falls
        mosi_o <= (i < 31) ? w[30-i] : ~w[0]; // stale data is inverted after the frame
      end
      repeat (6) @(posedge clk_i);
      cs_n_o <= 1'b1;
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule // spi_master_model

// ---- sim/lpm_poll_config_tb_top.sv ----
`timescale 1ns/10ps
`include "lpm_poll_consts.vh"
module lpm_poll_config_tb_top;
  localparam WIN = 8;
  localparam DEB = 20;
  reg               clk_i, rst_n_i, fault_i, int_flag_i, low_power_i, poll_tick_i;
  reg [`PRG_CH-1:0] prg_to_batt_i, prg_wetting_current_sel_i;
  wire              sclk, cs_n, mosi, miso, miso_oe, miso_w;
  wire [`GND_CH-1:0] gnd_wetting_current, gnd_drv, gnd_smp;
  wire [`PRG_CH-1:0] prg_hi, prg_drv, prg_smp, prg_lvl;
  integer           err_total, compares, valid;
  reg [31:0]        rep;
  reg [21:0]        nxt;
  reg [21:0]        shadow [0:31];
  // a released line shows the inverse, so a stale bit never passes for data
  assign miso_w = miso_oe ? miso : ~miso;
  lpm_poll_config #(.POLL_WIN_CYC(WIN), .DEB_EXT_CYC(DEB)) u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
    .fault_i(fault_i), .int_flag_i(int_flag_i), .low_power_i(low_power_i),
    .poll_tick_i(poll_tick_i), .prg_to_batt_i(prg_to_batt_i),
    .prg_wetting_current_sel_i(prg_wetting_current_sel_i), .gnd_wetting_current_sel_o(gnd_wetting_current), .prg_hi_cur_o(prg_hi),
    .gnd_drive_o(gnd_drv), .prg_drive_o(prg_drv), .gnd_sample_o(gnd_smp),
    .prg_sample_o(prg_smp), .prg_level_mode_o(prg_lvl));
  spi_master_model u_mst (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi), .miso_i(miso_w));
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (err_total == 0 && compares > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  function [21:0] msk(input [6:0] a);
    msk = (a == `ADR_GND_CUR || a == `ADR_GND_SLOW) ? 22'h3fff :
          (a == `ADR_PRG_SLOW || a == `ADR_PRG_DEB) ? 22'h00ff : 22'h0;
  endfunction
  // one frame; the reply belongs to the previous good frame
  task acc(input integer n, input [6:0] a, input wr, input [23:0] d);
    begin
      u_mst.xfer(n, {a, wr, d}, rep);
      if (valid && n == 32) chk(rep, {8'h00, fault_i, int_flag_i, nxt});
      if (n == 32 && wr) shadow[a[4:0]] = msk(a) & d[21:0];
      if (n == 32) nxt = shadow[a[4:0]];
      valid = 1;
    end
  endtask
  // reset values, masked writes, read back, unmapped place, short frame
  task t_regs;
    integer p, a;
    begin
      for (p = 0; p < 3; p = p + 1)
        for (a = 23; a < 28; a = a + 1)
          acc(32, a[6:0], p == 1, 24'hff_ffff);
      acc(31, `ADR_GND_CUR, 1'b1, 24'h00_0000);
      acc(32, `ADR_GND_CUR, 1'b0, 24'h00_0000);
      acc(32, `ADR_GND_CUR, 1'b0, 24'h00_0000);
    end
  endtask
  // slow channels poll on ticks 1 and 5; debounce channels keep driving
  task t_poll;
    integer k, n;
    reg [13:0] dg;
    reg [7:0] dp;
    begin
      acc(32, `ADR_GND_CUR, 1'b1, 24'h00_0f0f);
      acc(32, `ADR_GND_SLOW, 1'b1, 24'h00_00ff);
      acc(32, `ADR_PRG_SLOW, 1'b1, 24'h00_000f);
      acc(32, `ADR_PRG_DEB, 1'b1, 24'h00_0033);
      chk(gnd_wetting_current, 14'h0f0f);
      chk(prg_lvl, 8'h33);
      chk(prg_hi, 8'ha0);
      low_power_i <= 1'b1;
      for (k = 1; k < 6; k = k + 1) begin
        dg = (k == 1 || k == 5) ? 14'h3fff : 14'h3f00;
        dp = (k == 1 || k == 5) ? 8'hff : 8'hf0;
        poll_tick_i <= 1'b1;
        @(posedge clk_i);
        poll_tick_i <= 1'b0;
        @(posedge clk_i) #1;
        chk(gnd_drv, dg);
        chk(prg_drv, dp);
        for (n = 0; n < 40 && gnd_smp == 0; n = n + 1) @(posedge clk_i) #1;
        if (n == 40) begin
          err_total = err_total + 1;
          test_done;
        end
        chk(gnd_smp, dg);
        chk(prg_smp, dp & 8'hcc);
        chk(prg_drv, dp & 8'h33);
        repeat (DEB - 2) @(posedge clk_i);
        #1 chk(prg_drv, dp & 8'h33);
        repeat (2) @(posedge clk_i);
        #1 chk(prg_smp, dp & 8'h33);
        chk(prg_drv, 8'h00);
        repeat (2) @(posedge clk_i);
        #1 chk(prg_drv, 8'h00);
        repeat (4) @(posedge clk_i);
      end
      low_power_i <= 1'b0;
    end
  endtask
  // leaving low power mid-window drops every drive and judges nothing
  task t_abort;
    integer n;
    reg hit;
    begin
      hit = 1'b0;
      repeat (2) @(posedge clk_i);
      low_power_i <= 1'b1;
      poll_tick_i <= 1'b1;
      @(posedge clk_i);
      poll_tick_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      low_power_i <= 1'b0;
      #1 chk(gnd_drv, 14'h3fff);
      repeat (2) @(posedge clk_i);
      #1 chk(gnd_drv, 14'h0000);
      chk(prg_drv, 8'h00);
      for (n = 0; n < WIN + DEB; n = n + 1) begin
        @(posedge clk_i) #1;
        if (gnd_smp != 0 || prg_smp != 0) hit = 1'b1;
      end
      chk(hit, 1'b0);
    end
  endtask
  // reset, then the scenarios
  initial begin
    err_total = 0;
    compares = 0;
    valid = 0;
    nxt = 22'h0;
    for (compares = 0; compares < 32; compares = compares + 1) shadow[compares] = 22'h0;
    compares = 0;
    rst_n_i = 1'b0;
    fault_i = 1'b1;
    int_flag_i = 1'b0;
    low_power_i = 1'b0;
    poll_tick_i = 1'b0;
    prg_to_batt_i = 8'ha5;
    prg_wetting_current_sel_i = 8'h0f;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_regs;
    t_poll;
    t_abort;
    test_done;
  end
endmodule // lpm_poll_config_tb_top
